/* File: hw/fac_pkg.sv */
/*
  Shared constants, types and helpers for the flash access and protection controller.
  Assumes a 24-bit CPU byte address space and a 20-bit APB address.
*/
package fac_pkg;
  localparam int AW = 24;
  // APB register indices, byte address is four times the index
  localparam logic [17:0] WAITCTL_IDX = 18'h05320;
  localparam logic [17:0] WPROT_IDX = 18'h17ffc;
  localparam logic [17:0] RPROT_IDX = 18'h17ffe;
  localparam logic [17:0] ERASE_IDX = 18'h06000;
  localparam logic [17:0] STAT_IDX = 18'h06001;
  // CPU memory map
  localparam logic [AW-1:0] RAM_LAST = 24'h000fff;
  localparam logic [AW-1:0] P2_BASE = 24'h005000;
  localparam logic [AW-1:0] P2_LAST = 24'h005fff;
  localparam logic [AW-1:0] FL_BASE = 24'h008000;
  localparam logic [AW-1:0] FL_LAST = 24'h017fff;
  localparam logic [AW-1:0] DISP_BASE = 24'h080000;
  localparam logic [AW-1:0] DISP_LAST = 24'h08055f;
  localparam logic [AW-1:0] VEC_BASE = FL_BASE;
  // Protect words as flash word addresses
  localparam logic [14:0] WP_WORD = 15'h7ffe;
  localparam logic [14:0] RP_WORD = 15'h7fff;
  // Reset values and counts
  localparam logic [2:0] WAIT_RST = 3'h3;
  localparam logic [2:0] WAIT_SINGLE = 3'h4;
  localparam logic [2:0] CNT_BOOT = 3'h4;
  localparam logic [3:0] PROT_RST = 4'hf;
  // Erase register fields
  localparam int ER_CHIP_BIT = 0;
  localparam int ER_SECT_BIT = 1;
  localparam int ER_NUM_LSB = 4;

  typedef enum logic [1:0] {
    TGT_RAM = 2'b00,
    TGT_FLASH = 2'b01,
    TGT_SLOW = 2'b10,
    TGT_OTHER = 2'b11
  } fac_tgt_t;

  typedef enum logic [1:0] {
    FS_BOOT_WP = 2'b00,
    FS_BOOT_RP = 2'b01,
    FS_IDLE = 2'b10,
    FS_READ = 2'b11
  } fac_fl_st_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic wr;
    logic [1:0] be;
    logic [15:0] wdata;
  } fac_dreq_t;

  function automatic fac_tgt_t fac_decode(input logic [AW-1:0] a);
    if (a <= RAM_LAST) return TGT_RAM;
    if (a >= FL_BASE && a <= FL_LAST) return TGT_FLASH;
    if ((a >= P2_BASE && a <= P2_LAST) || (a >= DISP_BASE && a <= DISP_LAST)) return TGT_SLOW;
    return TGT_OTHER;
  endfunction

  // Cycles minus one; reserved codes fall back to the slowest setting
  function automatic logic [2:0] fac_wait_load(input logic [2:0] code);
    if (code == WAIT_SINGLE) return 3'h0;
    if (code < WAIT_SINGLE) return code + 3'h1;
    return CNT_BOOT;
  endfunction

  function automatic logic [1:0] fac_region(input logic [AW-1:0] a);
    logic [2:0] r;
    r = a[16:14] - 3'h2;
    return r[1:0];
  endfunction

  function automatic logic [14:0] fac_fl_word(input logic [AW-1:0] a);
    logic [AW-1:0] off;
    off = a - FL_BASE;
    return off[15:1];
  endfunction
endpackage

/* File: hw/fac_wait_ctr.sv */
/*
  Down counter that times flash read wait states.
  Assumes load and value come from logic on the same clock.
*/
module fac_wait_ctr
  import fac_pkg::*;
#(
  parameter int W = 3,
  parameter logic [W-1:0] RST = CNT_BOOT
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] cnt_r;

  // RL19 one bus cycle per edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= RST;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done = (cnt_r == '0);
endmodule

/* File: hw/fac_ram.sv */
/*
  Internal RAM array, 16-bit words with byte enables.
  Assumes the caller drives one access per cycle; read is combinational.
*/
module fac_ram
  import fac_pkg::*;
#(
  parameter int DEPTH = 2048,
  parameter int RAW = 11
)(
  input wire logic pclk,
  input wire logic we,
  input wire logic [1:0] be,
  input wire logic [RAW-1:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem [DEPTH];

  // RL17 single cycle write
  always_ff @(posedge pclk) begin
    if (we && be[0]) begin
      mem[addr][7:0] <= wdata[7:0];
    end
    if (we && be[1]) begin
      mem[addr][15:8] <= wdata[15:8];
    end
  end

  assign rdata = mem[addr];
endmodule

/* File: hw/fac_flash_access_protect_ctrl.sv */
/*
  Flash access and protection controller: serializes flash fetch against flash or slow data
  and RAM fetch against RAM data, times flash reads, applies write and data-read protection, and
  holds the wait-state and erase registers on APB.
  Assumes the CPU, flash array and slow bus logic all run on pclk.
*/
// Operation
// RL1: Flash fetch waits while data goes to flash or slow regions.
// RL2: RAM fetch waits while a data access uses the RAM.
// RL3: Flash decoded at 0x8000 to 0x17fff, sixteen 4K sectors.
// RL4: Vector table base is the start of flash.
// RL5: Flash is programmed only by full 16-bit writes.
// RL6: Whole-array erase and per-sector erase of 4K sectors.
// RL7: Software keeps the last 32 bits of sector 15 for protection.
// RL8: Write and read protection apply per 16K region; protected writes rejected.
// RL9: Protected data reads return zero; fetches still get true contents.
// RL10: Protect bit zero means protected; bits start as one.
// RL11: Write-protect word bits 3..0 cover regions top to bottom.
// RL12: Read-protect word bits 3..1; lowest region never read-protected.
// RL13: Software keeps read-protect bit 0 at one.
// RL14: Wait-state register has 3-bit field, resets to three, upper bits zero.
// RL15: Codes 0..3 give 2..5 cycles, code 4 one cycle, 5..7 reserved.
// RL16: Software picks a wait setting suited to the core clock rate.
// RL17: Internal RAM at 0x0 to 0xfff, one cycle per access.
// RL18: Application leaves top 64 bytes of RAM to the debugger.
// RL19: One bus cycle is one core clock period.
// RL20: CPU writes flash only with 16-bit stores.
// RL21: Protected flash write completes without changing contents.
module fac_flash_access_protect_ctrl
  import fac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [19:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic f_req,
  input wire logic [AW-1:0] f_addr,
  output logic f_ack,
  output logic [15:0] f_rdata,
  input wire logic d_req,
  input wire fac_dreq_t d_req_info,
  output logic d_ack,
  output logic [15:0] d_rdata,
  output logic fl_rd,
  output logic fl_wr,
  output logic [14:0] fl_addr,
  output logic [15:0] fl_wdata,
  input wire logic [15:0] fl_rdata,
  output logic fl_erase_chip,
  output logic fl_erase_sector,
  output logic [3:0] fl_sector,
  output logic ext_req,
  output fac_dreq_t ext_info,
  input wire logic ext_ack,
  input wire logic [15:0] ext_rdata,
  output logic [AW-1:0] vector_base
);
  fac_tgt_t d_tgt, f_tgt;
  fac_fl_st_t st_r;
  fac_dreq_t ext_info_r;
  logic d_ack_r, f_ack_r, d_run_r, f_run_r, own_d_r, ext_req_r, fl_rd_r, fl_wr_r;
  logic fl_erase_chip_r, fl_erase_sector_r;
  logic [3:0] fl_sector_r, wp_r, rp_r, er_num;
  logic [2:0] wait_sel_r, ctr_val;
  logic [14:0] fl_addr_r;
  logic [15:0] fl_wdata_r, d_rdata_r, f_rdata_r, ram_rdata;
  logic [31:0] prdata_r;
  logic d_out, dp, fp, f_blk_fl, f_fl_busy;
  logic g_d_ram, g_d_fl_rd, g_d_fl_wr, g_d_ext, g_f_fl, g_f_ram, g_f_nil;
  logic ctr_load, ctr_done, fl_done, wp_ok, rp_blk, ram_we;
  logic [1:0] d_reg;
  logic [10:0] ram_addr;
  logic [17:0] idx;
  logic mapped, acc, wr_wait, wr_erase;

  // RL3 address decode
  assign d_tgt = fac_decode(d_req_info.addr);
  assign f_tgt = fac_decode(f_addr);
  // RL4 vector base
  assign vector_base = VEC_BASE;

  // RL8 region of the data address
  assign d_reg = fac_region(d_req_info.addr);
  // RL11 write-protect bit per region
  assign wp_ok = wp_r[d_reg];
  // RL12 lowest region never read-protected
  assign rp_blk = (d_reg != 2'h0) && !rp_r[d_reg];

  assign d_out = d_req && !d_ack_r;
  assign dp = d_out && !d_run_r;
  assign fp = f_req && !f_ack_r && !f_run_r;
  assign f_fl_busy = (st_r == FS_READ) && !own_d_r;
  // RL1 fetch held behind flash or slow data
  assign f_blk_fl = d_out && (d_tgt == TGT_FLASH || d_tgt == TGT_SLOW);

  assign g_d_ram = dp && d_tgt == TGT_RAM;
  assign g_d_fl_rd = dp && d_tgt == TGT_FLASH && st_r == FS_IDLE && !d_req_info.wr;
  assign g_d_fl_wr = dp && d_tgt == TGT_FLASH && st_r == FS_IDLE && d_req_info.wr;
  // RL1 slow data waits for a running flash fetch
  assign g_d_ext = dp && (d_tgt == TGT_OTHER || (d_tgt == TGT_SLOW && !f_fl_busy));
  assign g_f_fl = fp && f_tgt == TGT_FLASH && st_r == FS_IDLE && !f_blk_fl;
  // RL2 RAM fetch yields to RAM data
  assign g_f_ram = fp && f_tgt == TGT_RAM && !(d_out && d_tgt == TGT_RAM);
  assign g_f_nil = fp && (f_tgt == TGT_SLOW || f_tgt == TGT_OTHER);

  // RAM port shared by data and fetch
  assign ram_addr = g_d_ram ? d_req_info.addr[11:1] : f_addr[11:1];
  assign ram_we = g_d_ram && d_req_info.wr;

  fac_ram #(
    .DEPTH(2048),
    .RAW(11)
  ) u_ram (
    .pclk(pclk),
    .we(ram_we),
    .be(d_req_info.be),
    .addr(ram_addr),
    .wdata(d_req_info.wdata),
    .rdata(ram_rdata)
  );

  // RL15 read cycles from the wait field
  assign ctr_load = (st_r == FS_BOOT_WP && ctr_done) || g_d_fl_rd || g_f_fl;
  assign ctr_val = (st_r == FS_BOOT_WP) ? CNT_BOOT : fac_wait_load(wait_sel_r);
  assign fl_done = (st_r == FS_READ) && ctr_done;

  fac_wait_ctr #(
    .W(3),
    .RST(CNT_BOOT)
  ) u_ctr (
    .pclk(pclk),
    .presetn(presetn),
    .load(ctr_load),
    .load_val(ctr_val),
    .done(ctr_done)
  );

  // Flash read sequencer, boot loads the protect words first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= FS_BOOT_WP;
      fl_rd_r <= 1'b1;
      fl_addr_r <= WP_WORD;
      own_d_r <= 1'b0;
      wp_r <= PROT_RST;
      rp_r <= PROT_RST;
    end else begin
      unique case (st_r)
        FS_BOOT_WP: begin
          if (ctr_done) begin
            // RL10 bit zero protects
            wp_r <= fl_rdata[3:0];
            fl_addr_r <= RP_WORD;
            st_r <= FS_BOOT_RP;
          end
        end
        FS_BOOT_RP: begin
          if (ctr_done) begin
            rp_r <= fl_rdata[3:0];
            fl_rd_r <= 1'b0;
            st_r <= FS_IDLE;
          end
        end
        FS_IDLE: begin
          if (g_f_fl) begin
            fl_addr_r <= fac_fl_word(f_addr);
          end else if (g_d_fl_rd || g_d_fl_wr) begin
            fl_addr_r <= fac_fl_word(d_req_info.addr);
          end
          if (g_d_fl_rd || g_f_fl) begin
            fl_rd_r <= 1'b1;
            own_d_r <= g_d_fl_rd;
            st_r <= FS_READ;
          end
        end
        FS_READ: begin
          if (ctr_done) begin
            fl_rd_r <= 1'b0;
            st_r <= FS_IDLE;
          end
        end
      endcase
    end
  end

  // Flash program strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_wr_r <= 1'b0;
      fl_wdata_r <= 16'h0000;
    end else begin
      // RL5 only full 16-bit writes
      // RL8 protected region rejected
      fl_wr_r <= g_d_fl_wr && wp_ok && (d_req_info.be == 2'h3);
      if (g_d_fl_wr) begin
        fl_wdata_r <= d_req_info.wdata;
      end
    end
  end

  // Slow and other data regions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_req_r <= 1'b0;
      ext_info_r <= '0;
    end else if (g_d_ext) begin
      ext_req_r <= 1'b1;
      ext_info_r <= d_req_info;
    end else if (ext_ack) begin
      ext_req_r <= 1'b0;
    end
  end

  // Data answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_ack_r <= 1'b0;
      d_run_r <= 1'b0;
      d_rdata_r <= 16'h0000;
    end else begin
      // RL21 protected write still acknowledged
      // RL17 RAM answers next edge
      d_ack_r <= g_d_ram || g_d_fl_wr || (fl_done && own_d_r) || (ext_req_r && ext_ack);
      if (g_d_fl_rd || g_d_ext) begin
        d_run_r <= 1'b1;
      end else if ((fl_done && own_d_r) || (ext_req_r && ext_ack)) begin
        d_run_r <= 1'b0;
      end
      if (g_d_ram && !d_req_info.wr) begin
        d_rdata_r <= ram_rdata;
      end else if (fl_done && own_d_r) begin
        // RL9 protected data read is zero
        d_rdata_r <= rp_blk ? 16'h0000 : fl_rdata;
      end else if (ext_req_r && ext_ack) begin
        d_rdata_r <= ext_rdata;
      end
    end
  end

  // Fetch answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_ack_r <= 1'b0;
      f_run_r <= 1'b0;
      f_rdata_r <= 16'h0000;
    end else begin
      f_ack_r <= g_f_ram || g_f_nil || (fl_done && !own_d_r);
      if (g_f_fl) begin
        f_run_r <= 1'b1;
      end else if (fl_done) begin
        f_run_r <= 1'b0;
      end
      if (g_f_ram) begin
        f_rdata_r <= ram_rdata;
      end else if (fl_done && !own_d_r) begin
        // RL9 fetch ignores read protection
        f_rdata_r <= fl_rdata;
      end else if (g_f_nil) begin
        f_rdata_r <= 16'h0000;
      end
    end
  end

  // APB decode
  assign idx = paddr[19:2];
  assign acc = psel && penable;
  assign mapped = (paddr[1:0] == 2'h0) && (idx == WAITCTL_IDX || idx == WPROT_IDX ||
                  idx == RPROT_IDX || idx == ERASE_IDX || idx == STAT_IDX);
  assign wr_wait = acc && pwrite && mapped && idx == WAITCTL_IDX;
  assign wr_erase = acc && pwrite && mapped && idx == ERASE_IDX;
  assign er_num = pwdata[ER_NUM_LSB +: 4];

  // RL14 wait field, resets to three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_sel_r <= WAIT_RST;
    end else if (wr_wait) begin
      wait_sel_r <= pwdata[2:0];
    end
  end

  // RL6 chip and sector erase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_erase_chip_r <= 1'b0;
      fl_erase_sector_r <= 1'b0;
      fl_sector_r <= 4'h0;
    end else begin
      fl_erase_chip_r <= wr_erase && pwdata[ER_CHIP_BIT] && (&wp_r) && st_r == FS_IDLE;
      fl_erase_sector_r <= wr_erase && pwdata[ER_SECT_BIT] && wp_r[er_num[3:2]] && st_r == FS_IDLE;
      if (wr_erase) begin
        fl_sector_r <= er_num;
      end
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_r <= 32'h00000000;
      if (paddr[1:0] == 2'h0) begin
        if (idx == WAITCTL_IDX) prdata_r[2:0] <= wait_sel_r;
        if (idx == WPROT_IDX) prdata_r[3:0] <= wp_r;
        if (idx == RPROT_IDX) prdata_r[3:0] <= rp_r;
        if (idx == STAT_IDX) prdata_r[2:0] <= {st_r != FS_BOOT_WP && st_r != FS_BOOT_RP, ext_req_r, fl_rd_r};
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign f_ack = f_ack_r;
  assign f_rdata = f_rdata_r;
  assign d_ack = d_ack_r;
  assign d_rdata = d_rdata_r;
  assign fl_rd = fl_rd_r;
  assign fl_wr = fl_wr_r;
  assign fl_addr = fl_addr_r;
  assign fl_wdata = fl_wdata_r;
  assign fl_erase_chip = fl_erase_chip_r;
  assign fl_erase_sector = fl_erase_sector_r;
  assign fl_sector = fl_sector_r;
  assign ext_req = ext_req_r;
  assign ext_info = ext_info_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_start;
    st_r == FS_IDLE && (g_d_fl_rd || g_f_fl);
  endsequence
  sequence s_rd5;
    (st_r == FS_READ) [*5] ##1 st_r == FS_IDLE;
  endsequence
  sequence s_rd1;
    st_r == FS_READ ##1 st_r == FS_IDLE;
  endsequence

  AST_WAIT_FIVE: assert property (s_rd_start and wait_sel_r == 3'h3 |=> s_rd5) // RL15
    else $error("code 3 flash read not five cycles");
  AST_WAIT_ONE: assert property (s_rd_start and wait_sel_r == 3'h4 |=> s_rd1) // RL15
    else $error("code 4 flash read not one cycle");
  AST_RP_ZERO: assert property (fl_done && own_d_r && rp_blk |=> d_ack_r && d_rdata_r == 16'h0000) // RL9
    else $error("protected data read returned nonzero");
  AST_FETCH_TRUE: assert property (fl_done && !own_d_r |=> f_ack_r && f_rdata_r == $past(fl_rdata)) // RL9
    else $error("fetch did not return flash contents");
  AST_WP_BLOCK: assert property (g_d_fl_wr && !wp_ok |=> !fl_wr_r && d_ack_r) // RL21
    else $error("protected write reached flash or hung");
  AST_RAM_ONE: assert property (d_req && !d_ack_r && !d_run_r && d_tgt == TGT_RAM |=> d_ack_r) // RL17
    else $error("RAM data access not one cycle");
  AST_RAM_SERIAL: assert property (fp && f_tgt == TGT_RAM && d_out && d_tgt == TGT_RAM |=> !f_ack_r) // RL2
    else $error("RAM fetch ran beside RAM data");
  AST_FL_SERIAL: assert property (fp && f_tgt == TGT_FLASH && f_blk_fl |=> !f_ack_r && !f_run_r) // RL1
    else $error("flash fetch ran beside slow data");
  AST_WAIT_HOLD: assert property (!wr_wait |=> $stable(wait_sel_r)) // RL14
    else $error("wait field changed without a write");
  AST_ERASE_PROT: assert property (wr_erase && pwdata[ER_SECT_BIT] && !wp_r[er_num[3:2]] |=> !fl_erase_sector) // RL8
    else $error("erase of protected sector issued");
endmodule

/* File: bench/fac_flash_model.sv */
/*
  Far-side model: flash array and slow-bus responder for the access controller.
  Assumes the controller drives it from pclk; the bench sets the slow-bus stall count.
*/
module fac_flash_model
  import fac_pkg::*;
#(
  parameter logic [15:0] WP_INIT = 16'hffff,
  parameter logic [15:0] RP_INIT = 16'hffff
)(
  input wire logic pclk,
  input wire logic fl_rd,
  input wire logic fl_wr,
  input wire logic [14:0] fl_addr,
  input wire logic [15:0] fl_wdata,
  output logic [15:0] fl_rdata,
  input wire logic fl_erase_chip,
  input wire logic fl_erase_sector,
  input wire logic [3:0] fl_sector,
  input wire logic ext_req,
  input wire fac_dreq_t ext_info,
  output logic ext_ack,
  output logic [15:0] ext_rdata,
  input wire logic [3:0] ext_stall
);
  logic [15:0] mem [32768];
  logic [15:0] last_r;
  logic [3:0] wait_r;
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 16'(i) ^ 16'ha5c3;
    end
    // protect words at the tail, read bit 0 kept at one
    mem[32766] = WP_INIT;
    mem[32767] = RP_INIT | 16'h0001;
    {last_r, wait_r, ext_ack, ext_rdata} = '0;
  end
  // Released data lines show the inverse of the last word
  assign fl_rdata = fl_rd ? mem[fl_addr] : ~last_r;
  always @(posedge pclk) begin
    last_r <= fl_rdata;
    if (fl_wr) begin
      mem[fl_addr] <= fl_wdata;
    end
    if (fl_erase_chip || fl_erase_sector) begin
      for (int j = 0; j < 32768; j++) begin
        if (fl_erase_chip || j[14:11] == fl_sector) begin
          mem[j] <= 16'hffff;
        end
      end
    end
    ext_ack <= 1'b0;
    ext_rdata <= ~ext_rdata;
    if (ext_req && !ext_ack) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r == ext_stall) begin
        wait_r <= 4'h0;
        ext_ack <= 1'b1;
        ext_rdata <= ext_info.addr[15:0] ^ 16'h3c3c;
      end
    end
  end
endmodule

/* File: bench/test_flash_access_protect_ctrl.sv */
/*
  Self-checking bench for the flash access and protection controller.
  Assumes fac_flash_model as flash array and slow bus; the bench is CPU and APB master.
*/
module test_flash_access_protect_ctrl
  import fac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic f;
    logic [AW-1:0] a;
    logic wr;
    logic [1:0] be;
    logic [15:0] wd;
    logic [15:0] e;
  } fac_row_t;
  localparam logic [15:0] WP = 16'hfffb;
  localparam logic [15:0] RP = 16'hfffd;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, f_req, f_ack, d_req, d_ack, err;
  logic fl_rd, fl_wr, fl_erase_chip, fl_erase_sector, ext_req, ext_ack;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd32;
  logic [AW-1:0] f_addr, vector_base;
  logic [15:0] f_rdata, d_rdata, fl_wdata, fl_rdata, ext_rdata, rd, rd2;
  logic [14:0] fl_addr;
  logic [3:0] fl_sector, ext_stall;
  fac_dreq_t d_req_info, ext_info;
  int n_errors, compares, c1, c2, base;
  fac_row_t rows [17];
  logic [31:0] ecmd [3] = '{32'h000000c2, 32'h00000082, 32'h00000001};
  logic [AW-1:0] eadr [3] = '{24'h014000, 24'h010000, 24'h008000};

  fac_flash_access_protect_ctrl uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .f_req, .f_addr, .f_ack, .f_rdata, .d_req, .d_req_info, .d_ack, .d_rdata, .fl_rd,
    .fl_wr, .fl_addr, .fl_wdata, .fl_rdata, .fl_erase_chip, .fl_erase_sector, .fl_sector, .ext_req,
    .ext_info, .ext_ack, .ext_rdata, .vector_base);
  fac_flash_model #(.WP_INIT(WP), .RP_INIT(RP)) far (.pclk, .fl_rd, .fl_wr, .fl_addr, .fl_wdata, .fl_rdata,
    .fl_erase_chip, .fl_erase_sector, .fl_sector, .ext_req, .ext_info, .ext_ack, .ext_rdata, .ext_stall);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [15:0] pat(input logic [AW-1:0] a);
    logic [AW-1:0] o;
    o = a - 24'h008000;
    return o[16:1] ^ 16'ha5c3;
  endfunction

  function automatic int ncyc(input logic [2:0] c);
    return c == 3'h4 ? 1 : (c < 3'h4 ? c + 2 : 5);
  endfunction

  task automatic finish_test();
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tmo();
    n_errors++;
    finish_test();
  endtask

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmpw(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp(n, {16'h0, e}, {16'h0, g});
  endtask

  task automatic apb(input logic w, input logic [17:0] idx, input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) tmo();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic acc(input logic f, input logic [AW-1:0] a, input logic wr, input logic [1:0] be,
                     input logic [15:0] wd, output logic [15:0] r, output int n);
    @(posedge pclk);
    if (f) begin
      f_req <= 1'b1;
      f_addr <= a;
    end else begin
      d_req <= 1'b1;
      d_req_info <= '{a, wr, be, wd};
    end
    n = 0;
    @(negedge pclk);
    while ((f ? f_ack : d_ack) !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 40) tmo();
    r = f ? f_rdata : d_rdata;
    @(posedge pclk);
    if (f) f_req <= 1'b0;
    else d_req <= 1'b0;
  endtask

  task automatic rst();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd32 = '0;
    for (int k = 0; rd32[2] !== 1'b1; k++) begin
      if (k == 20) tmo();
      apb(1'b0, STAT_IDX, 32'h0, rd32, err);
    end
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    tmo();
  end

  initial begin
    {psel, penable, pwrite, f_req, d_req, presetn, paddr, pwdata, f_addr, d_req_info, ext_stall} = '0;
    n_errors = 0;
    compares = 0;
    // RAM traffic stays below the debugger area
    // flash stores are 16-bit apart from one refused byte store
    rows = '{'{0, 24'h000100, 1, 2'h3, 16'h1234, 16'h0}, '{0, 24'h000100, 0, 2'h3, 16'h0, 16'h1234},
      '{1, 24'h000100, 0, 2'h3, 16'h0, 16'h1234}, '{0, 24'h008000, 0, 2'h3, 16'h0, pat(24'h008000)},
      '{0, 24'h017ffa, 0, 2'h3, 16'h0, pat(24'h017ffa)}, '{0, 24'h00c000, 0, 2'h3, 16'h0, 16'h0},
      '{1, 24'h00c000, 0, 2'h3, 16'h0, pat(24'h00c000)}, '{0, 24'h00bffe, 0, 2'h3, 16'h0, pat(24'h00bffe)},
      '{0, 24'h010000, 1, 2'h3, 16'h0, 16'h0}, '{0, 24'h010000, 0, 2'h3, 16'h0, pat(24'h010000)},
      '{0, 24'h014000, 1, 2'h3, 16'h0f0f, 16'h0}, '{0, 24'h014000, 0, 2'h3, 16'h0, 16'h0f0f},
      '{0, 24'h014002, 1, 2'h1, 16'h0, 16'h0}, '{0, 24'h014002, 0, 2'h3, 16'h0, pat(24'h014002)},
      '{0, 24'h005000, 0, 2'h3, 16'h0, 16'h6c3c}, '{1, 24'h018000, 0, 2'h3, 16'h0, 16'h0},
      '{0, 24'h080000, 0, 2'h3, 16'h0, 16'h3c3c}};
    rst();
    apb(1'b0, WAITCTL_IDX, 32'h0, rd32, err);
    cmp("wait ctl reset", 32'h3, rd32);
    apb(1'b0, WPROT_IDX, 32'h0, rd32, err);
    cmp("write protect word", {28'h0, WP[3:0]}, rd32);
    apb(1'b0, RPROT_IDX, 32'h0, rd32, err);
    cmp("read protect word", {28'h0, RP[3:0]}, rd32);
    cmp("vector base", 32'h00008000, {8'h0, vector_base});
    apb(1'b0, 18'h00001, 32'h0, rd32, err);
    cmp("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, WAITCTL_IDX, 32'h000000ff, rd32, err);
    apb(1'b0, WAITCTL_IDX, 32'h0, rd32, err);
    cmp("wait ctl reserved bits", 32'h7, rd32);
    // clock rate not modelled, so every code is tried
    for (int c = 4; c < 12; c++) begin
      apb(1'b1, WAITCTL_IDX, c % 8, rd32, err);
      acc(1'b0, 24'h008002, 1'b0, 2'h3, 16'h0, rd, c1);
      cmp("flash read cycles", ncyc(3'(c % 8)) + 1, c1);
      cmpw("flash read data", pat(24'h008002), rd);
    end
    foreach (rows[i]) begin
      acc(rows[i].f, rows[i].a, rows[i].wr, rows[i].be, rows[i].wd, rd, c1);
      if (!rows[i].wr) cmpw("access data", rows[i].e, rd);
      if (rows[i].a < 24'h001000) cmp("ram cycles", 32'h1, c1);
    end
    ext_stall <= 4'h6;
    acc(1'b1, 24'h008000, 1'b0, 2'h3, 16'h0, rd, base);
    fork
      acc(1'b1, 24'h008000, 1'b0, 2'h3, 16'h0, rd, c1);
      acc(1'b0, 24'h005000, 1'b0, 2'h3, 16'h0, rd2, c2);
    join
    cmp("fetch and slow data serialized", 32'h1, {31'h0, (c1 > c2 ? c1 : c2) >= base + 6});
    cmpw("fetch data", pat(24'h008000), rd);
    cmpw("slow data", 16'h6c3c, rd2);
    fork
      acc(1'b1, 24'h000100, 1'b0, 2'h3, 16'h0, rd, c1);
      acc(1'b0, 24'h000100, 1'b0, 2'h3, 16'h0, rd2, c2);
    join
    cmp("ram fetch cycles", 32'h2, c1);
    cmp("ram data cycles", 32'h1, c2);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ERASE_IDX, ecmd[i], rd32, err);
      acc(1'b0, eadr[i], 1'b0, 2'h3, 16'h0, rd, c1);
      cmpw("erase result", i == 0 ? 16'hffff : pat(eadr[i]), rd);
    end
    acc(1'b0, 24'h013ffe, 1'b0, 2'h3, 16'h0, rd, c1);
    cmpw("neighbour sector", pat(24'h013ffe), rd);
    apb(1'b1, WAITCTL_IDX, 32'h1, rd32, err);
    rst();
    apb(1'b0, WAITCTL_IDX, 32'h0, rd32, err);
    cmp("wait ctl after reset", 32'h3, rd32);
    finish_test();
  end
endmodule
